// ==== common/sacc_map.vh ====
/*
  Constants for the conversion sequencer: data width, cycle counts and
  the start-to-edge window. Included by the step and sequencer design files; no logic here.
*/
`ifndef SACC_MAP_VH
`define SACC_MAP_VH

// =====================================================================
// Widths and counts
// =====================================================================
`define SACC_DATA_W 8
`define SACC_CONV_CYCLES 8
`define SACC_RESULT_RST 8'h00
// Start to first counted edge window, in ns
`define SACC_EDGE_WINDOW_NS 50
// System clock period in ns (10 MHz)
`define SACC_SYS_PERIOD_NS 100
// Internal conversion clock half period, in system cycles
`define SACC_INT_HALF 1
// Output data coding flag selected by supply mode
`define SACC_CODE_BINARY 1'b0
`define SACC_CODE_TWOS 1'b1

`endif

// ==== design/sacc_edge_det.v ====
/*
  Edge detector for one synchronous level: registered copy and
  one-cycle pulses for falling and rising edges.
  Assumes the input is already synchronous to sys_clk.
*/
`timescale 1ns/1ps
module sacc_edge_det #(
  parameter RST_LEVEL = 1'b1
)(
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Level in, pulses out
  input wire level_in,
  output wire fall_pulse,
  output wire rise_pulse
);

  reg last_reg;

  // Remember previous level
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      last_reg <= RST_LEVEL;
    else
      last_reg <= level_in;
  end

  // Edge pulses
  assign fall_pulse = last_reg & ~level_in;
  assign rise_pulse = ~last_reg & level_in;

endmodule // sacc_edge_det

// ==== design/sacc_sar_step.v ====
/*
  Successive-approximation step logic: given the register, the bit
  index being tried and the comparator answer, forms the next trial.
  Pure combinational; assumes comparator settles within one step.
*/
`timescale 1ns/1ps
`include "sacc_map.vh"
module sacc_sar_step #(
  parameter DATA_W = `SACC_DATA_W
)(
  // Current state
  input wire [DATA_W-1:0] approx_in,
  input wire [2:0] bit_idx,
  input wire cmp_keep,
  // Next register value
  output reg [DATA_W-1:0] approx_out
);

  integer i;

  // Keep or drop the tried bit, then set the next lower trial bit
  always @*
  begin
    approx_out = approx_in;
    for (i = 0; i < DATA_W; i = i + 1)
    begin
      if (i == bit_idx)
        approx_out[i] = cmp_keep;
      if ((i + 1) == bit_idx)
        approx_out[i] = 1'b1;
    end
  end

endmodule // sacc_sar_step

// ==== design/sacc_conv_ctrl.v ====
/*
  Conversion sequencer for an 8-bit successive-approximation ADC with
  track/hold. Starts on sample strobe or on chip select with read,
  steps the approximation register on falling conversion-clock edges,
  latches the result and drives busy, interrupt and hold control.
  Assumes all pins are synchronous to sys_clk; the analog comparator
  answer arrives on cmp_high; the conversion clock is either external
  (conv_clk_ext) or a divided internal clock gated per conversion.

*/
`timescale 1ns/1ps
`include "sacc_map.vh"
module sacc_conv_ctrl #(
  parameter DATA_W = `SACC_DATA_W,
  parameter CONV_CYCLES = `SACC_CONV_CYCLES
)(
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Host strobes
  input wire sample_trigger_n,
  input wire cs_n,
  input wire rd_n,
  // Conversion clock
  input wire use_ext_clk,
  input wire conv_clk_ext,
  // Supply mode and comparator
  input wire neg_supply,
  input wire cmp_high,
  // Data bus, three signals
  input wire [DATA_W-1:0] data_in,
  output wire [DATA_W-1:0] data_out,
  output wire data_oe,
  // Status
  output wire busy_n,
  output wire int_n,
  output wire hold_en,
  output wire conv_clk_int,
  output wire [DATA_W-1:0] approx_trial,
  output wire data_twos
);

  // ===================================================================
  // Constants
  // ===================================================================
  // Start window expressed in system cycles, rounded up, at least 1
  localparam integer WIN_RAW = (`SACC_EDGE_WINDOW_NS +
    `SACC_SYS_PERIOD_NS - 1) / `SACC_SYS_PERIOD_NS;
  localparam integer WIN_CYC = (WIN_RAW < 1) ? 1 : WIN_RAW;
  localparam [2:0] WIN_CNT = WIN_CYC[2:0];

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ARM = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  // ===================================================================
  // Declarations
  // ===================================================================
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] win_reg;
  reg [2:0] win_next;
  reg [3:0] edge_cnt_reg;
  reg [3:0] edge_cnt_next;
  reg [DATA_W-1:0] approx_reg;
  reg [DATA_W-1:0] approx_next;
  reg [DATA_W-1:0] result_reg;
  reg [DATA_W-1:0] result_next;
  reg int_n_reg;
  reg int_n_next;
  reg int_clk_reg;
  reg [3:0] div_reg;
  reg start_seen_reg;
  reg start_clear_reg;
  wire rd_act;
  wire start_fall;
  wire rd_fall;
  wire cs_rise;
  wire rd_rise;
  wire int_fall;
  wire ext_fall;
  wire clk_fall;
  wire [DATA_W-1:0] step_val;
  wire [2:0] bit_idx;
  wire busy_act;
  wire start_cmd;

  // ===================================================================
  // Strobe edges
  // ===================================================================
  assign rd_act = ~cs_n & ~rd_n;

  sacc_edge_det #(.RST_LEVEL(1'b1)) u_st_edge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .level_in(sample_trigger_n),
    .fall_pulse(start_fall),
    .rise_pulse()
  );

  sacc_edge_det #(.RST_LEVEL(1'b1)) u_rd_edge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .level_in(~rd_act),
    .fall_pulse(rd_fall),
    .rise_pulse()
  );

  sacc_edge_det #(.RST_LEVEL(1'b1)) u_cs_edge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .level_in(cs_n),
    .fall_pulse(),
    .rise_pulse(cs_rise)
  );

  sacc_edge_det #(.RST_LEVEL(1'b1)) u_rdn_edge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .level_in(rd_n),
    .fall_pulse(),
    .rise_pulse(rd_rise)
  );

  sacc_edge_det #(.RST_LEVEL(1'b1)) u_ext_edge (
    .sys_clk(sys_clk),
    .sys_rst(1'b0), // Free clock: reset must not fake a fall
    .level_in(conv_clk_ext),
    .fall_pulse(ext_fall),
    .rise_pulse()
  );

  sacc_edge_det #(.RST_LEVEL(1'b0)) u_int_edge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .level_in(int_clk_reg),
    .fall_pulse(int_fall),
    .rise_pulse()
  );

  // read start only counts with start strobe high
  assign start_cmd = start_fall | (rd_fall & sample_trigger_n);

  // external clock edges used only while converting
  assign clk_fall = use_ext_clk ? ext_fall : int_fall;

  // ===================================================================
  // Sequencer state, not reset so reset cannot abort a conversion
  // ===================================================================
  // start capture and conversion state held through reset
  always @(posedge sys_clk)
  begin
    start_seen_reg <= start_cmd;
    state_reg <= state_next;
    win_reg <= win_next;
    edge_cnt_reg <= edge_cnt_next;
    approx_reg <= approx_next;
    result_reg <= result_next;
  end

  // Reset flag; clears the sequencer only while it is idle
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      start_clear_reg <= 1'b1;
    else
      start_clear_reg <= 1'b0;
  end

  assign bit_idx = 3'h7 - edge_cnt_reg[2:0] + 3'h1;

  sacc_sar_step #(.DATA_W(DATA_W)) u_step (
    .approx_in(approx_reg),
    .bit_idx(bit_idx),
    .cmp_keep(cmp_high),
    .approx_out(step_val)
  );

  // Next state of the sequencer
  always @*
  begin
    state_next = state_reg;
    win_next = win_reg;
    edge_cnt_next = edge_cnt_reg;
    approx_next = approx_reg;
    result_next = result_reg;
    if (start_clear_reg && (state_reg == ST_IDLE))
    begin
      state_next = ST_IDLE;
      approx_next = `SACC_RESULT_RST;
      result_next = `SACC_RESULT_RST;
      edge_cnt_next = 4'h0;
      win_next = 3'h0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start_seen_reg)
          begin
            state_next = ST_ARM;
            win_next = WIN_CNT;
            edge_cnt_next = 4'h0;
            approx_next = {1'b1, {(DATA_W-1){1'b0}}};
          end
        end
        ST_ARM:
        begin
          // edges inside the window are not counted
          if (win_reg != 3'h0)
            win_next = win_reg - 3'h1;
          else if (clk_fall)
          begin
            state_next = ST_CONV;
            edge_cnt_next = 4'h1;
          end
        end
        ST_CONV:
        begin
          if (clk_fall)
          begin
            approx_next = step_val;
            edge_cnt_next = edge_cnt_reg + 4'h1;
            if (edge_cnt_reg == CONV_CYCLES[3:0])
              state_next = ST_DONE;
          end
        end
        ST_DONE:
        begin
          // copy to latch, then clear register
          result_next = approx_reg;
          approx_next = `SACC_RESULT_RST;
          state_next = ST_IDLE;
        end
        default:
          state_next = ST_IDLE;
      endcase
    end
  end

  // ===================================================================
  // Interrupt
  // ===================================================================
  // Interrupt next value; completion wins over clear
  always @*
  begin
    int_n_next = int_n_reg;
    // clear on rising chip select or read
    if (cs_rise | rd_rise)
      int_n_next = 1'b1;
    // set regardless of earlier uncleared state
    if (state_reg == ST_DONE)
      int_n_next = 1'b0;
  end

  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      int_n_reg <= 1'b1;
    else
      int_n_reg <= int_n_next;
  end

  // ===================================================================
  // Internal conversion clock
  // ===================================================================
  // runs only while a conversion is active
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      int_clk_reg <= 1'b0;
      div_reg <= 4'h0;
    end
    else if (!busy_act || use_ext_clk)
    begin
      int_clk_reg <= 1'b0;
      div_reg <= 4'h0;
    end
    else if (div_reg == (`SACC_INT_HALF - 1))
    begin
      int_clk_reg <= ~int_clk_reg;
      div_reg <= 4'h0;
    end
    else
      div_reg <= div_reg + 4'h1;
  end

  // ===================================================================
  // Data bus
  // ===================================================================
  // latch drives the bus straight; reset clears it only while idle
  assign data_out = result_reg;

  // ===================================================================
  // Outputs
  // ===================================================================
  assign busy_act = (state_reg == ST_ARM) | (state_reg == ST_CONV);
  assign busy_n = ~busy_act;
  // track again once busy returns high
  assign hold_en = busy_act;
  assign int_n = int_n_reg;
  assign conv_clk_int = int_clk_reg;
  assign data_oe = rd_act;
  assign approx_trial = approx_reg;
  assign data_twos = neg_supply ? `SACC_CODE_TWOS : `SACC_CODE_BINARY;

endmodule // sacc_conv_ctrl

// ==== verification/sacc_adc_model.sv ====
/*
  Far-side model: comparator on the trial word and a free-running
  external conversion clock.
  Assumes the testbench sets the sampled input level as a code.
*/
`timescale 1ns/1ps
module sacc_adc_model (
  // Clock
  input wire sys_clk,
  // Trial word and held input level
  input wire [7:0] approx_trial,
  input wire [7:0] vin_code,
  // Comparator answer and external clock
  output wire cmp_high,
  output reg conv_clk_ext
);
  reg [1:0] div_reg;

  initial
  begin
    div_reg = 2'h0;
    conv_clk_ext = 1'b0;
  end

  // =====================================================================
  // Comparator
  // =====================================================================
  // keep when input at or above trial
  assign cmp_high = (approx_trial <= vin_code);

  // =====================================================================
  // External clock, four system cycles a period
  // =====================================================================
  // never gated, 50/50 duty
  always @(posedge sys_clk)
  begin
    div_reg <= div_reg + 2'h1;
    conv_clk_ext <= div_reg[1];
  end
endmodule // sacc_adc_model

// ==== verification/sacc_checker.sv ====
/*
  Port checker for the conversion sequencer.
  Bound to every sacc_conv_ctrl instance; one clock domain.
*/
`timescale 1ns/1ps
module sacc_checker (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Inputs watched
  input wire sample_trigger_n,
  input wire cs_n,
  input wire rd_n,
  input wire neg_supply,
  // Outputs watched
  input wire [7:0] data_out,
  input wire data_oe,
  input wire busy_n,
  input wire int_n,
  input wire hold_en,
  input wire conv_clk_int,
  input wire [7:0] approx_trial,
  input wire data_twos
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // =====================================================================
  // Steps of a conversion
  // =====================================================================
  sequence s_start;
    busy_n && $fell(sample_trigger_n);
  endsequence
  sequence s_done;
    $rose(busy_n);
  endsequence
  sequence s_busy_two;
    !busy_n ##1 !busy_n;
  endsequence

  property p_st_start;
    s_start |-> ##[1:3] (!busy_n && hold_en);
  endproperty
  property p_hold;
    hold_en == !busy_n;
  endproperty
  property p_busy_min;
    $fell(busy_n) |-> !busy_n [*8];
  endproperty
  property p_busy_max;
    !busy_n |-> ##[1:80] busy_n;
  endproperty
  property p_int_set;
    s_done |-> ##[0:1] !int_n;
  endproperty
  property p_int_clr;
    busy_n && ($rose(cs_n) || $rose(rd_n)) |-> ##[0:2] int_n;
  endproperty
  property p_rst_int;
    disable iff (1'b0) sys_rst |-> int_n;
  endproperty
  property p_latch;
    s_busy_two |-> $stable(data_out);
  endproperty
  property p_sar_clr;
    s_done |-> ##1 (approx_trial == 8'h00);
  endproperty
  property p_twos;
    $stable(neg_supply) |-> (data_twos == neg_supply);
  endproperty
  property p_oe;
    data_oe == (!cs_n && !rd_n);
  endproperty
  property p_clk_stop;
    busy_n [*4] |-> !conv_clk_int;
  endproperty
  property p_trial_msb;
    $fell(busy_n) |-> (approx_trial == 8'h80);
  endproperty

  a_st_start: assert property (p_st_start)
    else $error("start strobe did not begin a conversion");
  a_hold: assert property (p_hold)
    else $error("hold control disagrees with busy");
  a_busy_min: assert property (p_busy_min)
    else $error("busy too short");
  a_busy_max: assert property (p_busy_max)
    else $error("busy too long");
  a_int_set: assert property (p_int_set)
    else $error("interrupt missing at completion");
  a_int_clr: assert property (p_int_clr)
    else $error("interrupt not cleared by strobe rise");
  a_rst_int: assert property (p_rst_int)
    else $error("interrupt low during reset");
  a_latch: assert property (p_latch)
    else $error("output latch changed mid conversion");
  a_sar_clr: assert property (p_sar_clr)
    else $error("approximation register not cleared");
  a_twos: assert property (p_twos)
    else $error("coding flag wrong");
  a_oe: assert property (p_oe)
    else $error("data enable wrong");
  a_clk_stop: assert property (p_clk_stop)
    else $error("internal clock runs when idle");
  a_trial_msb: assert property (p_trial_msb)
    else $error("first trial word is not the top bit");
endmodule // sacc_checker

bind sacc_conv_ctrl sacc_checker u_chk (.sys_clk, .sys_rst,
  .sample_trigger_n, .cs_n, .rd_n, .neg_supply, .data_out, .data_oe,
  .busy_n, .int_n, .hold_en, .conv_clk_int, .approx_trial, .data_twos);

// ==== verification/sacc_conv_ctrl_tb.sv ====
/*
  Self-checking bench for the conversion sequencer.
  Assumes the comparator and clock model in sacc_adc_model.
*/
`timescale 1ns/1ps
module sacc_conv_ctrl_tb;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b0;
  reg sample_trigger_n = 1'b1;
  reg cs_n = 1'b1;
  reg rd_n = 1'b1;
  reg use_ext_clk = 1'b0;
  reg neg_supply = 1'b0;
  reg [7:0] vin_code = 8'h00;
  wire conv_clk_ext, cmp_high, data_oe, busy_n, int_n, hold_en;
  wire conv_clk_int, data_twos;
  wire [7:0] data_out, approx_trial;
  integer fails = 0;
  integer cmp_count = 0;

  always #50 sys_clk = ~sys_clk;

  sacc_conv_ctrl u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .sample_trigger_n(sample_trigger_n), .cs_n(cs_n), .rd_n(rd_n),
    .use_ext_clk(use_ext_clk), .conv_clk_ext(conv_clk_ext),
    .neg_supply(neg_supply), .cmp_high(cmp_high), .data_in(8'h00),
    .data_out(data_out), .data_oe(data_oe), .busy_n(busy_n),
    .int_n(int_n), .hold_en(hold_en), .conv_clk_int(conv_clk_int),
    .approx_trial(approx_trial), .data_twos(data_twos));

  sacc_adc_model u_model (.sys_clk(sys_clk), .approx_trial(approx_trial),
    .vin_code(vin_code), .cmp_high(cmp_high), .conv_clk_ext(conv_clk_ext));

  // =====================================================================
  // Counted conversion-clock falls, window cycle left out
  // =====================================================================
  reg ext_last = 1'b0;
  reg int_last = 1'b0;
  reg busy_last = 1'b1;
  integer clk_falls = 0;

  always @(posedge sys_clk)
  begin
    ext_last <= conv_clk_ext;
    int_last <= conv_clk_int;
    busy_last <= busy_n;
    if (!busy_n && busy_last)
      clk_falls <= 0;
    else if (!busy_n && (use_ext_clk ? (ext_last && !conv_clk_ext) :
        (int_last && !conv_clk_int)))
      clk_falls <= clk_falls + 1;
  end

  // =====================================================================
  // Shared tasks
  // =====================================================================
  task check(input [7:0] seen, input [7:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  end
  endtask

  task wait_busy(input v);
    integer n;
  begin
    n = 0;
    while (busy_n !== v && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n = n + 1;
    end
    check({7'h00, busy_n}, {7'h00, v});
  end
  endtask

  task conclude;
  begin
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  // =====================================================================
  // Scenarios
  // =====================================================================
  // Strobe start, optional reset mid-run, optional read
  task conv_st(input [7:0] code, input rst_mid, input do_read);
  begin
    @(posedge sys_clk);
    vin_code <= code;
    sample_trigger_n <= 1'b0;
    wait_busy(1'b0);
    check({7'h00, hold_en}, 8'h01);
    if (rst_mid)
    begin
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      @(posedge sys_clk);
      #1;
      check({7'h00, int_n}, 8'h01);
      @(posedge sys_clk);
      sys_rst <= 1'b0;
    end
    wait_busy(1'b1);
    check(clk_falls[7:0], 8'h09);
    check({7'h00, hold_en}, 8'h00);
    @(posedge sys_clk);
    #1;
    check({7'h00, int_n}, 8'h00);
    check(data_out, code);
    if (do_read)
    begin
      @(posedge sys_clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      @(posedge sys_clk);
      #1;
      check({7'h00, data_oe}, 8'h01);
      check(data_out, code);
    end
    @(posedge sys_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    sample_trigger_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check({7'h00, int_n}, {7'h00, do_read});
    check({7'h00, busy_n}, 8'h01);
  end
  endtask

  // Chip select and read start, external free clock
  task conv_rd(input [7:0] code);
  begin
    @(posedge sys_clk);
    use_ext_clk <= 1'b1;
    vin_code <= code;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    wait_busy(1'b0);
    wait_busy(1'b1);
    check(clk_falls[7:0], 8'h09);
    @(posedge sys_clk);
    #1;
    check(data_out, code);
    check({7'h00, int_n}, 8'h00);
    @(posedge sys_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    use_ext_clk <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check({7'h00, int_n}, 8'h01);
  end
  endtask

  // Coding flag follows the supply mode
  task coding;
  begin
    @(posedge sys_clk);
    neg_supply <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check({7'h00, data_twos}, 8'h01);
    @(posedge sys_clk);
    neg_supply <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check({7'h00, data_twos}, 8'h00);
  end
  endtask

  // Main sequence
  initial
  begin
    sys_rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // start only after busy high, over 25 cycles apart
    conv_st(8'h00, 1'b0, 1'b1);
    conv_st(8'hFF, 1'b0, 1'b0);
    conv_st(8'hA5, 1'b0, 1'b0);
    conv_st(8'h5A, 1'b1, 1'b1);
    conv_rd(8'h3C);
    conv_rd(8'hC3);
    coding;
    conclude;
  end

  // Watchdog
  initial
  begin
    #2000000;
    fails = fails + 1;
    conclude;
  end
endmodule // sacc_conv_ctrl_tb
